/* design/canecb_regs.svh */
// Register offsets, reset values and counts of the CAN error capture block
`ifndef CANECB_REGS_SVH
`define CANECB_REGS_SVH
`define CANECB_ADDR_ECC     7'h0c
`define CANECB_ADDR_EWL     7'h0d
`define CANECB_ADDR_RXC     7'h0e
`define CANECB_ADDR_TXC     7'h0f
`define CANECB_ADDR_TXB_LO  7'h10
`define CANECB_ADDR_TXB_HI  7'h1c
`define CANECB_ADDR_RAM_LO  7'h60
`define CANECB_ADDR_RAM_HI  7'h6f
`define CANECB_EWL_RST      8'h60
`define CANECB_CNT_RST      8'h00
`define CANECB_TX_OFF_LOAD  8'h7f
`define CANECB_TX_FORCE     8'hff
`define CANECB_CNT_STEP     8'h08
`define CANECB_CNT_ONE      8'h01
`define CANECB_CNT_TOP      8'hff
`define CANECB_INC8_LIMIT   8'hf8
`define CANECB_PASSIVE_LIM  8'h80
`define CANECB_FI_FF        7
`define CANECB_FI_RTR       6
`define CANECB_DSTART_STD   7'h13
`define CANECB_DSTART_EXT   7'h15
`define CANECB_DLC_MAX      4'h8
`endif

/* design/canecb_pkg.sv */
// Types of the CAN error capture block
`default_nettype none
package canecb_pkg;
  typedef enum logic [1:0] {
    ERR_BIT   = 2'b00,
    ERR_FORM  = 2'b01,
    ERR_STUFF = 2'b10,
    ERR_OTHER = 2'b11
  } canecb_err_t;
  typedef enum logic [4:0] {
    SEG_SOF       = 5'b00011,
    SEG_ID28_21   = 5'b00010,
    SEG_ID20_18   = 5'b00110,
    SEG_SRTR      = 5'b00100,
    SEG_IDE       = 5'b00101,
    SEG_ID17_13   = 5'b00111,
    SEG_ID12_5    = 5'b01111,
    SEG_ID4_0     = 5'b01110,
    SEG_RTR       = 5'b01100,
    SEG_RES1      = 5'b01101,
    SEG_RES0      = 5'b01001,
    SEG_DLC       = 5'b01011,
    SEG_DATA      = 5'b01010,
    SEG_CRC       = 5'b01000,
    SEG_CRC_DEL   = 5'b11000,
    SEG_ACK       = 5'b11001,
    SEG_ACK_DEL   = 5'b11011,
    SEG_EOF       = 5'b11010,
    SEG_INTERMIS  = 5'b10010,
    SEG_ACT_FLAG  = 5'b10001,
    SEG_PAS_FLAG  = 5'b10110,
    SEG_TOL_DOM   = 5'b10011,
    SEG_ERR_DEL   = 5'b10111,
    SEG_OVL_FLAG  = 5'b11100
  } canecb_seg_t;
  typedef enum logic [1:0] {
    ST_ACTIVE  = 2'b00,
    ST_BUSOFF  = 2'b01,
    ST_WAITIDL = 2'b10
  } canecb_state_t;
endpackage
`default_nettype wire

/* design/canecb_txbuf_mem.sv */
// Transmit buffer RAM with registered bus and transmitter read ports
`default_nettype none
module canecb_txbuf_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Write port
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrIdx,
  input  wire logic [WIDTH-1:0] wrData,
  // Bus read port with register bypass
  input  wire logic             rdEn,
  input  wire logic [AW-1:0]    rdIdx,
  input  wire logic             extSel,
  input  wire logic [WIDTH-1:0] extData,
  output logic      [WIDTH-1:0] rdData,
  // Transmitter read port
  input  wire logic [AW-1:0]    txIdx,
  output logic      [WIDTH-1:0] txData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= extSel ? extData : mem[rdIdx];
    end else begin
      rdData <= '0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      txData <= '0;
    end else begin
      txData <= mem[txIdx];
    end
  end
endmodule // canecb_txbuf_mem
`default_nettype wire

/* design/canecb_core.sv */
// CAN error capture, error counters and transmit buffer
// Overview of operation
// RULE1: Error type 00 bit,01 form,10 stuff,11 other
// RULE2: Direction bit 1 receive, 0 transmit
// RULE3: Five-bit segment code of failing frame part
// RULE4: Segment code follows current frame position
// RULE5: Bus error raises interrupt and captures position
// RULE6: Capture holds until read once, then re-arms
// RULE7: Interrupt register read clears bus error flag
// RULE8: Warning limit resets to 96
// RULE9: Warning limit writable only in reset mode
// RULE10: New limit acts only after leaving reset
// RULE11: Receive counter live, cleared, writable in reset
// RULE12: Bus-off clears receive counter, blocks its writes
// RULE13: Receive counter write acts after reset mode
// RULE14: Transmit counter live, cleared, writable in reset
// RULE15: Bus-off loads 127, counts 128 bus-free events
// RULE16: Write 0-254 in bus-off waits one bus-free
// RULE17: Write 255 forces bus-off on leaving reset; written in ST_WAITIDL, leaving reset loads 127 and clears the receive counter, state stays ST_WAITIDL
// RULE18: Transmit counter write acts after reset mode
// RULE19: Forced bus-off then recovers over 128 bus-frees
// RULE20: Reset mode during recovery freezes counter, bus-off
// RULE21: One 13-byte message at addresses 16 to 28
// RULE22: Info byte, 2 or 4 ids, data at 19/21
// RULE23: 96-108 direct RAM, 109-111 general bytes
// RULE24: Format bit 1 extended, plus remote and length
`default_nettype none
`include "canecb_regs.svh"
module canecb_core
  import canecb_pkg::*;
#(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Register port
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wrData,
  input  wire logic          wrStrobe,
  input  wire logic          rdStrobe,
  output logic      [DW-1:0] rdData,
  // Controller mode and interrupt register
  input  wire logic          resetMode,
  input  wire logic          busErrIntEnable,
  input  wire logic          intRegRead,
  // Bit stream processor events
  input  wire logic          busErrorEvent,
  input  wire canecb_err_t   errorTypeIn,
  input  wire logic          errorRxDir,
  input  wire canecb_seg_t   segmentIn,
  input  wire logic          rxCntInc,
  input  wire logic          rxCntInc8,
  input  wire logic          rxCntDec,
  input  wire logic          txCntInc8,
  input  wire logic          txCntDec,
  input  wire logic          busFreeEvent,
  // Status and interrupt outputs
  output logic               busErrIrq,
  output logic               busOff,
  output logic               waitBusIdle,
  output logic               errorWarning,
  output logic               errorPassive,
  output logic               warnChange,
  output logic               passiveChange,
  output logic               busOffChange,
  output logic               enterResetReq,
  // Transmit buffer towards the transmitter
  input  wire logic [3:0]    txRdIdx,
  output logic      [DW-1:0] txRdData,
  output logic               frameExtended,
  output logic               frameRemote,
  output logic      [3:0]    frameLength,
  output logic      [3:0]    dataByteCount,
  output logic      [AW-1:0] dataStartAddr
);
  logic [DW-1:0] captureReg;
  logic          captureLocked;
  logic [DW-1:0] warnLimit;
  logic [DW-1:0] rxCount;
  logic [DW-1:0] txCount;
  logic          forcePending;
  logic          resetModePrev;
  canecb_state_t state;
  canecb_state_t next_state;
  logic          leaveReset;
  logic          operating;
  logic          enterBusOff;
  logic          wrEcc;
  logic          wrEwl;
  logic          wrRx;
  logic          wrTx;
  logic          rdEcc;
  logic          inTxb;
  logic          inRam;
  logic          memWr;
  logic [AW-1:0] memOff;
  logic [3:0]    memIdx;
  logic          regSel;
  logic [DW-1:0] regData;
  logic          next_warning;
  logic          next_passive;
  logic          wrInfo;

  assign leaveReset = resetModePrev & ~resetMode;
  assign operating  = ~resetMode;

  // Address decoding
  always_comb begin
    inTxb = 1'b0;
    inRam = 1'b0;
    memOff = '0;
    if (addr >= `CANECB_ADDR_TXB_LO && addr <= `CANECB_ADDR_TXB_HI) begin // [RULE21]
      inTxb = 1'b1;
      memOff = addr - `CANECB_ADDR_TXB_LO;
    end else if (addr >= `CANECB_ADDR_RAM_LO && addr <= `CANECB_ADDR_RAM_HI) begin // [RULE23]
      inRam = 1'b1;
      memOff = addr - `CANECB_ADDR_RAM_LO;
    end
  end
  assign memIdx = memOff[3:0];
  assign memWr  = wrStrobe & (inTxb | inRam);
  assign wrInfo = wrStrobe & (addr == `CANECB_ADDR_TXB_LO || addr == `CANECB_ADDR_RAM_LO);

  assign wrEcc = wrStrobe & (addr == `CANECB_ADDR_ECC);
  assign wrEwl = wrStrobe & resetMode & (addr == `CANECB_ADDR_EWL); // [RULE9]
  assign wrRx  = wrStrobe & resetMode & (addr == `CANECB_ADDR_RXC); // [RULE11]
  assign wrTx  = wrStrobe & resetMode & (addr == `CANECB_ADDR_TXC); // [RULE14]
  assign rdEcc = rdStrobe & (addr == `CANECB_ADDR_ECC);

  // Register read multiplexer
  always_comb begin
    regSel  = 1'b1;
    regData = '0;
    if (addr == `CANECB_ADDR_ECC) begin
      regData = captureReg;
    end else if (addr == `CANECB_ADDR_EWL) begin
      regData = warnLimit;
    end else if (addr == `CANECB_ADDR_RXC) begin
      regData = rxCount; // [RULE11]
    end else if (addr == `CANECB_ADDR_TXC) begin
      regData = txCount; // [RULE14] [RULE15]
    end else if (!(inTxb || inRam)) begin
      regData = '0;
    end else begin
      regSel = 1'b0;
    end
  end

  // Error code capture
  always_ff @(posedge clock) begin
    if (rst) begin
      captureReg    <= '0;
      captureLocked <= 1'b0;
    end else if (busErrorEvent && !captureLocked) begin
      captureReg    <= {errorTypeIn, errorRxDir, segmentIn}; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
      captureLocked <= 1'b1;
    end else if (rdEcc) begin
      captureLocked <= 1'b0; // [RULE6]
    end
  end

  // Bus error interrupt flag; a new event wins over the clearing read
  always_ff @(posedge clock) begin
    if (rst) begin
      busErrIrq <= 1'b0;
    end else if (busErrorEvent && !captureLocked && busErrIntEnable) begin
      busErrIrq <= 1'b1; // [RULE5] [RULE6]
    end else if (intRegRead) begin
      busErrIrq <= 1'b0; // [RULE7]
    end
  end

  // Error warning limit
  always_ff @(posedge clock) begin
    if (rst) begin
      warnLimit <= `CANECB_EWL_RST; // [RULE8]
    end else if (wrEwl) begin
      warnLimit <= wrData; // [RULE9]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      resetModePrev <= 1'b0;
    end else begin
      resetModePrev <= resetMode;
    end
  end

  // Forced bus-off request, taken when reset mode is left
  always_ff @(posedge clock) begin
    if (rst) begin
      forcePending <= 1'b0;
    end else if (wrTx && wrData == `CANECB_TX_FORCE && state != ST_BUSOFF) begin
      forcePending <= 1'b1; // [RULE17]
    end else if (leaveReset) begin
      forcePending <= 1'b0;
    end
  end

  assign enterBusOff = (state == ST_ACTIVE && operating && txCntInc8
                        && txCount >= `CANECB_INC8_LIMIT)
                     || (forcePending && leaveReset); // [RULE17]

  // Bus-off state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (enterBusOff) begin
          next_state = ST_BUSOFF;
        end
      end
      ST_BUSOFF: begin
        if (wrTx && wrData != `CANECB_TX_FORCE) begin
          next_state = ST_WAITIDL; // [RULE16]
        end else if (operating && busFreeEvent && txCount == `CANECB_CNT_RST) begin
          next_state = ST_ACTIVE; // [RULE15] [RULE19]
        end
      end
      ST_WAITIDL: begin
        if (operating && busFreeEvent) begin
          next_state = ST_ACTIVE; // [RULE16]
        end
      end
      default: begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state         <= ST_ACTIVE;
      busOff        <= 1'b0;
      waitBusIdle   <= 1'b0;
      busOffChange  <= 1'b0;
      enterResetReq <= 1'b0;
    end else begin
      state         <= next_state;
      busOff        <= (next_state == ST_BUSOFF);
      waitBusIdle   <= (next_state == ST_WAITIDL);
      busOffChange  <= busOff != (next_state == ST_BUSOFF);
      enterResetReq <= enterBusOff; // [RULE17]
    end
  end

  // Transmit error counter
  always_ff @(posedge clock) begin
    if (rst) begin
      txCount <= `CANECB_CNT_RST; // [RULE14]
    end else if (enterBusOff) begin
      txCount <= `CANECB_TX_OFF_LOAD; // [RULE15] [RULE17]
    end else if (wrTx && !(state == ST_BUSOFF && wrData == `CANECB_TX_FORCE)) begin
      txCount <= wrData; // [RULE16] [RULE18]
    end else if (state == ST_BUSOFF) begin
      if (operating && busFreeEvent && txCount != `CANECB_CNT_RST) begin
        txCount <= txCount - `CANECB_CNT_ONE; // [RULE15] [RULE19] [RULE20]
      end
    end else if (state == ST_ACTIVE && operating && !forcePending) begin
      if (txCntInc8) begin
        txCount <= txCount + `CANECB_CNT_STEP;
      end else if (txCntDec && txCount != `CANECB_CNT_RST) begin
        txCount <= txCount - `CANECB_CNT_ONE;
      end
    end
  end

  // Receive error counter
  always_ff @(posedge clock) begin
    if (rst) begin
      rxCount <= `CANECB_CNT_RST; // [RULE11]
    end else if (enterBusOff) begin
      rxCount <= `CANECB_CNT_RST; // [RULE12] [RULE17]
    end else if (wrRx && state != ST_BUSOFF) begin
      rxCount <= wrData; // [RULE12] [RULE13]
    end else if (state == ST_ACTIVE && operating) begin
      if (rxCntInc8) begin
        rxCount <= (rxCount >= `CANECB_INC8_LIMIT) ? `CANECB_CNT_TOP
                                                   : rxCount + `CANECB_CNT_STEP;
      end else if (rxCntInc) begin
        rxCount <= (rxCount == `CANECB_CNT_TOP) ? rxCount : rxCount + `CANECB_CNT_ONE;
      end else if (rxCntDec && rxCount != `CANECB_CNT_RST) begin
        rxCount <= rxCount - `CANECB_CNT_ONE;
      end
    end
  end

  // Error status, judged only outside reset mode
  assign next_warning = (rxCount >= warnLimit) || (txCount >= warnLimit) || busOff;
  assign next_passive = (rxCount >= `CANECB_PASSIVE_LIM) || (txCount >= `CANECB_PASSIVE_LIM)
                        || busOff;

  always_ff @(posedge clock) begin
    if (rst) begin
      errorWarning  <= 1'b0;
      errorPassive  <= 1'b0;
      warnChange    <= 1'b0;
      passiveChange <= 1'b0;
    end else if (operating) begin
      errorWarning  <= next_warning; // [RULE10] [RULE13] [RULE18]
      errorPassive  <= next_passive; // [RULE13] [RULE18]
      warnChange    <= next_warning != errorWarning;
      passiveChange <= next_passive != errorPassive;
    end else begin
      warnChange    <= 1'b0;
      passiveChange <= 1'b0;
    end
  end

  // Frame information decode
  always_ff @(posedge clock) begin
    if (rst) begin
      frameExtended <= 1'b0;
      frameRemote   <= 1'b0;
      frameLength   <= '0;
      dataByteCount <= '0;
      dataStartAddr <= `CANECB_DSTART_STD;
    end else if (wrInfo) begin
      frameExtended <= wrData[`CANECB_FI_FF]; // [RULE24]
      frameRemote   <= wrData[`CANECB_FI_RTR]; // [RULE24]
      frameLength   <= wrData[3:0]; // [RULE24]
      if (wrData[`CANECB_FI_RTR]) begin
        dataByteCount <= '0;
      end else if (wrData[3:0] > `CANECB_DLC_MAX) begin
        dataByteCount <= `CANECB_DLC_MAX;
      end else begin
        dataByteCount <= wrData[3:0];
      end
      dataStartAddr <= wrData[`CANECB_FI_FF] ? `CANECB_DSTART_EXT
                                             : `CANECB_DSTART_STD; // [RULE22]
    end
  end

  // Transmit buffer RAM; also registers all bus read data
  canecb_txbuf_mem #(
    .WIDTH (DW),
    .DEPTH (16),
    .AW    (4)
  ) u_txbuf (
    .clock   (clock),
    .rst     (rst),
    .wrEn    (memWr),
    .wrIdx   (memIdx),
    .wrData  (wrData),
    .rdEn    (rdStrobe),
    .rdIdx   (memIdx),
    .extSel  (regSel),
    .extData (regData),
    .rdData  (rdData),
    .txIdx   (txRdIdx),
    .txData  (txRdData)
  ); // [RULE21] [RULE22] [RULE23]

  logic unusedWr;
  assign unusedWr = wrEcc;
endmodule // canecb_core
`default_nettype wire

/* test/canecb_core_assertions.sv */
// Concurrent checks of the CAN error capture block
`default_nettype none
`include "canecb_regs.svh"
module canecb_core_assertions
  import canecb_pkg::*;
#(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic          clock,
  input wire logic          rst,
  // Register port
  input wire logic [AW-1:0] addr,
  input wire logic          rdStrobe,
  // Capture and status
  input wire logic          busErrorEvent,
  input wire logic          busErrIntEnable,
  input wire logic          intRegRead,
  input wire logic          busErrIrq,
  input wire logic          busOff,
  input wire logic          busOffChange,
  input wire logic          enterResetReq,
  // Frame information
  input wire logic          frameExtended,
  input wire logic          frameRemote,
  input wire logic [3:0]    frameLength,
  input wire logic [3:0]    dataByteCount,
  input wire logic [AW-1:0] dataStartAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic locked;
  logic capRead;
  assign capRead = rdStrobe && addr == `CANECB_ADDR_ECC;
  // Tracks the capture lock
  always_ff @(posedge clock) begin
    if (rst) begin
      locked <= 1'b0;
    end else begin
      locked <= (locked && !capRead) || (busErrorEvent && !locked);
    end
  end
  sequence s_capture;
    busErrorEvent && busErrIntEnable && !locked;
  endsequence
  sequence s_off_entry;
    busOff && enterResetReq && busOffChange;
  endsequence
  a_irq_on_event: assert property (s_capture |=> busErrIrq)
    else $error("bus error interrupt missing");
  a_irq_cause: assert property ($rose(busErrIrq) |->
    $past(busErrorEvent && busErrIntEnable && !locked))
    else $error("bus error interrupt without armed capture");
  a_irq_clear: assert property (intRegRead && !busErrorEvent |=> !busErrIrq)
    else $error("bus error interrupt not cleared");
  a_irq_hold: assert property (busErrIrq && !intRegRead |=> busErrIrq)
    else $error("bus error interrupt dropped");
  a_off_entry: assert property ($rose(busOff) |-> s_off_entry)
    else $error("bus-off entry without reset request");
  a_req_pulse: assert property (enterResetReq |=> !enterResetReq)
    else $error("reset request longer than one cycle");
  a_data_start: assert property (dataStartAddr ==
    (frameExtended ? `CANECB_DSTART_EXT : `CANECB_DSTART_STD))
    else $error("data start address wrong");
  a_remote_len: assert property (frameRemote |-> dataByteCount == 4'h0)
    else $error("remote frame has data bytes");
  a_len_cap: assert property (!frameRemote |->
    dataByteCount == (frameLength > 4'h8 ? 4'h8 : frameLength))
    else $error("data byte count wrong");
endmodule // canecb_core_assertions
bind canecb_core canecb_core_assertions #(.AW(AW), .DW(DW)) chk_i (
  .clock(clock), .rst(rst), .addr(addr), .rdStrobe(rdStrobe),
  .busErrorEvent(busErrorEvent), .busErrIntEnable(busErrIntEnable),
  .intRegRead(intRegRead), .busErrIrq(busErrIrq), .busOff(busOff),
  .busOffChange(busOffChange), .enterResetReq(enterResetReq),
  .frameExtended(frameExtended), .frameRemote(frameRemote),
  .frameLength(frameLength), .dataByteCount(dataByteCount),
  .dataStartAddr(dataStartAddr)
);
`default_nettype wire

/* test/canecb_bus_model.sv */
// Bus side model: error events, counter steps and bus-free pulses
`default_nettype none
module canecb_bus_model
  import canecb_pkg::*;
(
  // Clock
  input  wire logic         clock,
  // Bit stream events
  output var logic          busErrorEvent,
  output var canecb_err_t   errorTypeIn,
  output var logic          errorRxDir,
  output var canecb_seg_t   segmentIn,
  output var logic [4:0]    cntStep,
  output var logic          busFreeEvent
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    busErrorEvent = 1'b0;
    errorTypeIn = ERR_OTHER;
    errorRxDir = 1'b0;
    segmentIn = SEG_INTERMIS;
    cntStep = 5'h00;
    busFreeEvent = 1'b0;
  end
  task automatic busErr(input canecb_err_t t, input logic d, input canecb_seg_t s);
    @(posedge clock);
    busErrorEvent <= 1'b1;
    errorTypeIn <= t;
    errorRxDir <= d;
    segmentIn <= s;
    @(posedge clock);
    busErrorEvent <= 1'b0;
    errorTypeIn <= canecb_err_t'(~t);
    errorRxDir <= ~d;
    segmentIn <= SEG_INTERMIS;
    #1;
  endtask
  task automatic cnt(input logic [4:0] m);
    @(posedge clock);
    cntStep <= m;
    @(posedge clock);
    cntStep <= 5'h00;
    #1;
  endtask
  task automatic busFree(input int n);
    repeat (n) begin
      @(posedge clock);
      busFreeEvent <= 1'b1;
      @(posedge clock);
      busFreeEvent <= 1'b0;
    end
    #1;
  endtask
endmodule // canecb_bus_model
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench of the CAN error capture block
`default_nettype none
module testbench
  import canecb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rdStrobe, wrStrobe;
  logic rst = 1'b1;
  logic [6:0] addr = 7'h00;
  logic [7:0] wrData = 8'h00;
  logic resetMode = 1'b1;
  logic busErrIntEnable = 1'b1;
  logic intRegRead = 1'b0;
  logic [3:0] txRdIdx = 4'h0;
  logic [7:0] rdData, txRdData;
  logic [3:0] frameLength, dataByteCount;
  logic [6:0] dataStartAddr;
  logic busErrorEvent, errorRxDir, busFreeEvent;
  logic [4:0] cntStep;
  canecb_err_t errorTypeIn;
  canecb_seg_t segmentIn;
  logic busErrIrq, busOff, waitBusIdle, errorWarning, errorPassive;
  logic frameExtended, frameRemote;
  logic warnChange, passiveChange, busOffChange, enterResetReq;
  int nFail, totalChecks, cycles;
  int nWarn, nPass, nOff, nReq;
  canecb_seg_t segs [4] = '{SEG_SOF, SEG_DATA, SEG_CRC, SEG_OVL_FLAG};
  logic [7:0] fi [3] = '{8'h85, 8'h4c, 8'h0c};
  logic [7:0] ds [3] = '{8'h15, 8'h13, 8'h13};
  logic [3:0] dc [3] = '{4'h5, 4'h0, 4'h8};
  initial rdStrobe = 1'b0;
  initial wrStrobe = 1'b0;
  canecb_core canecb_core_i (
    .clock(clock), .rst(rst), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .resetMode(resetMode), .busErrIntEnable(busErrIntEnable), .intRegRead(intRegRead),
    .busErrorEvent(busErrorEvent), .errorTypeIn(errorTypeIn), .errorRxDir(errorRxDir),
    .segmentIn(segmentIn), .rxCntInc(cntStep[4]), .rxCntInc8(cntStep[3]),
    .rxCntDec(cntStep[2]), .txCntInc8(cntStep[1]), .txCntDec(cntStep[0]),
    .busFreeEvent(busFreeEvent), .busErrIrq(busErrIrq), .busOff(busOff),
    .waitBusIdle(waitBusIdle), .errorWarning(errorWarning), .errorPassive(errorPassive),
    .warnChange(warnChange), .passiveChange(passiveChange), .busOffChange(busOffChange),
    .enterResetReq(enterResetReq),
    .txRdIdx(txRdIdx), .txRdData(txRdData), .frameExtended(frameExtended),
    .frameRemote(frameRemote), .frameLength(frameLength),
    .dataByteCount(dataByteCount), .dataStartAddr(dataStartAddr)
  );
  canecb_bus_model bus (
    .clock(clock), .busErrorEvent(busErrorEvent), .errorTypeIn(errorTypeIn),
    .errorRxDir(errorRxDir), .segmentIn(segmentIn), .cntStep(cntStep),
    .busFreeEvent(busFreeEvent)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic endSim();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    totalChecks++;
    if (s !== e) begin
      nFail++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic flg(input string nm, input logic s, input logic e);
    chk(nm, {7'h00, s}, {7'h00, e});
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    #1;
    chk($sformatf("addr %0d", a), rdData, e);
  endtask
  task automatic mode(input logic m);
    @(posedge clock);
    resetMode <= m;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic irqRead();
    @(posedge clock);
    intRegRead <= 1'b1;
    @(posedge clock);
    intRegRead <= 1'b0;
    #1;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (!rst) begin
      nWarn += warnChange;
      nPass += passiveChange;
      nOff += busOffChange;
      nReq += enterResetReq;
    end
    if (cycles == 3000) begin
      nFail++;
      endSim();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(7'h0d, 8'h60);
    rd(7'h0e, 8'h00);
    rd(7'h0f, 8'h00);
    wr(7'h0e, 8'h03);
    wr(7'h0f, 8'h04);
    mode(1'b0);
    wr(7'h0d, 8'h05);
    wr(7'h0e, 8'h09);
    wr(7'h0f, 8'h09);
    wr(7'h0c, 8'h55);
    rd(7'h0d, 8'h60);
    rd(7'h0e, 8'h03);
    rd(7'h0f, 8'h04);
    bus.cnt(5'h0a);
    rd(7'h0e, 8'h0b);
    rd(7'h0f, 8'h0c);
    bus.cnt(5'h05);
    rd(7'h0e, 8'h0a);
    rd(7'h0f, 8'h0b);
    for (int i = 0; i < 4; i++) begin
      bus.busErr(canecb_err_t'(i), i[0], segs[i]);
      flg("busErrIrq", busErrIrq, 1'b1);
      irqRead();
      flg("busErrIrq", busErrIrq, 1'b0);
      bus.busErr(ERR_OTHER, 1'b1, SEG_ACK);
      flg("busErrIrq", busErrIrq, 1'b0);
      rd(7'h0c, {i[1:0], i[0], segs[i]});
    end
    @(posedge clock);
    busErrIntEnable <= 1'b0;
    bus.busErr(ERR_BIT, 1'b0, SEG_EOF);
    flg("busErrIrq", busErrIrq, 1'b0);
    rd(7'h0c, {2'b00, 1'b0, SEG_EOF});
    mode(1'b1);
    wr(7'h0e, 8'hc8);
    flg("errorWarning", errorWarning, 1'b0);
    mode(1'b0);
    flg("errorWarning", errorWarning, 1'b1);
    flg("errorPassive", errorPassive, 1'b1);
    mode(1'b1);
    wr(7'h0d, 8'hff);
    flg("errorWarning", errorWarning, 1'b1);
    mode(1'b0);
    flg("errorWarning", errorWarning, 1'b0);
    rd(7'h0d, 8'hff);
    mode(1'b1);
    wr(7'h0f, 8'hff);
    flg("busOff", busOff, 1'b0);
    mode(1'b0);
    flg("busOff", busOff, 1'b1);
    rd(7'h0f, 8'h7f);
    rd(7'h0e, 8'h00);
    mode(1'b1);
    wr(7'h0e, 8'h05);
    rd(7'h0e, 8'h00);
    mode(1'b0);
    bus.busFree(100);
    rd(7'h0f, 8'h1b);
    mode(1'b1);
    bus.busFree(5);
    rd(7'h0f, 8'h1b);
    flg("busOff", busOff, 1'b1);
    mode(1'b0);
    bus.busFree(27);
    rd(7'h0f, 8'h00);
    flg("busOff", busOff, 1'b1);
    bus.busFree(1);
    flg("busOff", busOff, 1'b0);
    mode(1'b1);
    wr(7'h0f, 8'hff);
    mode(1'b0);
    mode(1'b1);
    wr(7'h0f, 8'h0a);
    flg("waitBusIdle", waitBusIdle, 1'b1);
    mode(1'b0);
    bus.busFree(1);
    flg("waitBusIdle", waitBusIdle, 1'b0);
    flg("busOff", busOff, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(7'h10, fi[i]);
      rd(7'h60, fi[i]);
      chk("dataStartAddr", {1'b0, dataStartAddr}, ds[i]);
      chk("dataByteCount", {4'h0, dataByteCount}, {4'h0, dc[i]});
      chk("frameInfo", {frameExtended, frameRemote, 2'b00, frameLength}, fi[i]);
    end
    wr(7'h1c, 8'ha5);
    rd(7'h6c, 8'ha5);
    wr(7'h6d, 8'h3c);
    rd(7'h6d, 8'h3c);
    rd(7'h1d, 8'h00);
    @(posedge clock);
    txRdIdx <= 4'hc;
    repeat (2) @(posedge clock);
    #1;
    chk("txRdData", txRdData, 8'ha5);
    chk("warnChange", 8'(nWarn), 8'h06);
    chk("passiveChange", 8'(nPass), 8'h04);
    chk("busOffChange", 8'(nOff), 8'h04);
    chk("enterResetReq", 8'(nReq), 8'h02);
    endSim();
  end
endmodule // testbench
`default_nettype wire
